// ### cmb_top.sv
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Two write masks, one per group of eight output cells, masked independently.
// - Both write masks reset to zero so every output cell accepts loads.
// - A set mask bit blocks host loads to that cell; others load normally.
// - Pin driver enable is an enable term ORed with direction output.
// - Output pin without enable equation drives from power-up onward.
// - Internal-node cells free their pin yet still feed back into the array.
// - Twenty-four input cells, one per pin of ports A, B and C.
// - Each input cell is a latch, an edge register or pass-through.
// - The host reads the input cell outputs over the internal bus.
// - Input cell enable selects either a product term or address strobe.
// - One enable term per four input cells: bits 3-0 and 7-4.
// - Address-strobe capture of upper address bits feeds the logic array.
// - Mailbox: master writes data-out, slave reads; slave writes inputs, master reads.
// - Slave read and write terms come from slave strobes and chip select.
// - Multiplexed bus address captured on strobe and presented outward.
// - Shared port driven only during a read of a mapped resource.
// - Control pin roles follow the host type; data bus is eight bits.
// - Unused control 2 serves as logic input; other spare pins are free.
// - Host loads into output cells override internal clock, preset and clear.
// - Output cells load on write trailing edge or while write is active.
module cmb_top (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [cmb_pkg::ADDR_BITS-1:0] i_shared_addr_data_port,
  output logic [cmb_pkg::BUS_BYTE-1:0] o_shared_addr_data_port_out,
  output logic o_shared_addr_data_port_oe_n,
  input wire logic i_control_pin_zero,
  input wire logic i_control_pin_one,
  input wire logic i_control_pin_two,
  input wire logic i_port_d_pin_zero,
  input wire cmb_pkg::cmb_bus_type_t i_bus_type,
  input wire logic i_muxed,
  input wire cmb_pkg::cmb_load_type_t i_load_type,
  input wire logic i_program_store_used,
  output logic o_control_two_logic,
  output logic [cmb_pkg::ADDR_BITS-1:0] o_latched_addr,
  input wire logic [cmb_pkg::INPUT_CELLS-1:0] i_port_pins,
  input wire cmb_pkg::cmb_in_mode_t [cmb_pkg::INPUT_CELLS-1:0] i_in_mode,
  input wire logic [cmb_pkg::INPUT_TERMS-1:0] i_in_strobe_sel,
  input wire logic [cmb_pkg::INPUT_TERMS-1:0] i_in_term_enable,
  output logic [cmb_pkg::INPUT_CELLS-1:0] o_input_cells,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_d,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_clk,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_preset,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_clear,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_comb_sel,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_comb_value,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_oe_term,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_dir_out,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_oe_eq_defined,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_pin_output,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_output_cells,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_cell_feedback,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_cell_pin_oe_n,
  input wire logic i_mailbox_en,
  input wire logic i_slave_rd_n,
  input wire logic i_slave_wr_n,
  input wire logic i_slave_cs,
  output logic [cmb_pkg::BUS_BYTE-1:0] o_mailbox_data,
  output logic o_mailbox_oe_n
);

  typedef enum logic {CMB_PH_IDLE, CMB_PH_WRITE} cmb_phase_t;

  typedef struct packed {
    cmb_phase_t phase;
    cmb_pkg::cmb_target_t target;
    logic [cmb_pkg::ADDR_BITS-1:0] addr;
    logic [cmb_pkg::BUS_BYTE-1:0] wdata;
    logic [cmb_pkg::BUS_BYTE-1:0] rdata;
    logic [cmb_pkg::BUS_BYTE-1:0] mask_ab;
    logic [cmb_pkg::BUS_BYTE-1:0] mask_bc;
    logic [cmb_pkg::BUS_BYTE-1:0] mailbox;
  } cmb_top_state_t;

  localparam cmb_top_state_t STATE_RESET = '{
    phase: CMB_PH_IDLE,
    target: cmb_pkg::CMB_TGT_NONE,
    addr: cmb_pkg::ADDR_RESET,
    wdata: cmb_pkg::BYTE_ZERO,
    rdata: cmb_pkg::BYTE_ZERO,
    mask_ab: cmb_pkg::MASK_RESET,
    mask_bc: cmb_pkg::MASK_RESET,
    mailbox: cmb_pkg::BYTE_ZERO
  };

  cmb_top_state_t st_reg;
  cmb_top_state_t st_next;

  cmb_load_if lif ();

  logic write_active;
  logic read_active;
  logic trailing;
  logic [cmb_pkg::ADDR_BITS-1:0] eff_addr;
  logic [cmb_pkg::BUS_BYTE-1:0] bus_data;
  cmb_pkg::cmb_target_t hit;
  logic slave_read;
  logic slave_write;
  logic [cmb_pkg::INPUT_TERMS-1:0] term_enable;
  logic read_claim;
  logic write_claim;

  //////////////////////////////////////////////////////////////////////////////
  // Any decoded resource claims the bus; unmapped space stays free for others
  function automatic logic mapped(input cmb_pkg::cmb_target_t tgt);
    return tgt != cmb_pkg::CMB_TGT_NONE;
  endfunction

  // Level loading follows the live decode so that a one-cycle strobe still lands
  function automatic logic group_load(
    input cmb_pkg::cmb_load_type_t ltype,
    input logic wr_on,
    input logic wr_end,
    input cmb_pkg::cmb_target_t live,
    input cmb_pkg::cmb_target_t held,
    input cmb_pkg::cmb_target_t group
  );
    logic go;
    if (ltype == cmb_pkg::CMB_LOAD_LEVEL)
      go = wr_on && live == group;
    else
      go = wr_end && held == group;
    return go;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Host strobes by bus type
  always_comb
  begin
    case (i_bus_type)
      cmb_pkg::CMB_BUS_RW_E:
      begin
        write_active = i_control_pin_one && !i_control_pin_zero;
        read_active = i_control_pin_one && i_control_pin_zero;
      end
      default:
      begin
        write_active = !i_control_pin_zero;
        read_active = !i_control_pin_one;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address and data paths
  // While the strobe is high the latch is transparent, so a single cycle
  // strobe still sees the live address
  assign eff_addr = (i_muxed && !i_port_d_pin_zero) ? st_reg.addr : i_shared_addr_data_port;
  assign bus_data = i_muxed ? i_shared_addr_data_port[cmb_pkg::BUS_BYTE-1:0]
                            : i_port_pins[cmb_pkg::BUS_BYTE-1:0];
  assign hit = cmb_pkg::cmb_decode(eff_addr);
  assign trailing = (st_reg.phase == CMB_PH_WRITE) && !write_active;
  assign write_claim = write_active && mapped(hit);

  // Control 2 becomes a plain logic input when not used as fetch strobe
  assign o_control_two_logic = i_program_store_used ? 1'b0 : i_control_pin_two;

  //////////////////////////////////////////////////////////////////////////////
  // Mailbox terms from the slave side
  assign slave_read = i_mailbox_en && i_slave_cs && !i_slave_rd_n;
  assign slave_write = i_mailbox_en && i_slave_cs && !i_slave_wr_n;

  always_comb
  begin
    term_enable = i_in_term_enable;
    // Port A nibbles are captured by the slave write term in mailbox use
    if (i_mailbox_en)
    begin
      term_enable[0] = slave_write;
      term_enable[1] = slave_write;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus sequencing and register file
  always_comb
  begin
    st_next = st_reg;
    if (i_port_d_pin_zero && i_muxed)
      st_next.addr = i_shared_addr_data_port;
    else if (!i_muxed)
      st_next.addr = i_shared_addr_data_port;
    case (hit)
      cmb_pkg::CMB_TGT_CELLS_AB: st_next.rdata = lif.cell_q[7:0];
      cmb_pkg::CMB_TGT_CELLS_BC: st_next.rdata = lif.cell_q[15:8];
      cmb_pkg::CMB_TGT_MASK_AB: st_next.rdata = st_reg.mask_ab;
      cmb_pkg::CMB_TGT_MASK_BC: st_next.rdata = st_reg.mask_bc;
      cmb_pkg::CMB_TGT_MAILBOX: st_next.rdata = st_reg.mailbox;
      cmb_pkg::CMB_TGT_INPUT_A: st_next.rdata = o_input_cells[7:0];
      cmb_pkg::CMB_TGT_INPUT_B: st_next.rdata = o_input_cells[15:8];
      cmb_pkg::CMB_TGT_INPUT_C: st_next.rdata = o_input_cells[23:16];
      default: st_next.rdata = cmb_pkg::BYTE_ZERO;
    endcase
    case (st_reg.phase)
      CMB_PH_IDLE:
      begin
        if (write_claim)
        begin
          st_next.phase = CMB_PH_WRITE;
          st_next.target = hit;
          st_next.wdata = bus_data;
        end
      end
      CMB_PH_WRITE:
      begin
        if (write_active)
          st_next.wdata = bus_data;
        else
        begin
          // Registers commit on the trailing edge with the last sampled byte
          case (st_reg.target)
            cmb_pkg::CMB_TGT_MASK_AB: st_next.mask_ab = st_reg.wdata;
            cmb_pkg::CMB_TGT_MASK_BC: st_next.mask_bc = st_reg.wdata;
            cmb_pkg::CMB_TGT_MAILBOX: st_next.mailbox = st_reg.wdata;
            default: st_next.mailbox = st_reg.mailbox;
          endcase
          st_next.phase = CMB_PH_IDLE;
          st_next.target = cmb_pkg::CMB_TGT_NONE;
        end
      end
      default: st_next.phase = CMB_PH_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      st_reg <= STATE_RESET;
    else
      st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output cell load strobes
  // Edge loading commits the byte sampled last before the strobe ended
  always_comb
  begin
    lif.load_ab = group_load(i_load_type, write_active, trailing, hit, st_reg.target,
                             cmb_pkg::CMB_TGT_CELLS_AB);
    lif.load_bc = group_load(i_load_type, write_active, trailing, hit, st_reg.target,
                             cmb_pkg::CMB_TGT_CELLS_BC);
    if (i_load_type == cmb_pkg::CMB_LOAD_LEVEL)
      lif.wdata = bus_data;
    else
      lif.wdata = st_reg.wdata;
    lif.mask_ab = st_reg.mask_ab;
    lif.mask_bc = st_reg.mask_bc;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared port drive; data is one cycle behind the address
  assign read_claim = read_active && mapped(hit);
  assign o_shared_addr_data_port_oe_n = !read_claim;
  assign o_shared_addr_data_port_out = st_reg.rdata;
  assign o_latched_addr = st_reg.addr;
  assign o_mailbox_data = st_reg.mailbox;
  assign o_mailbox_oe_n = !slave_read;

  //////////////////////////////////////////////////////////////////////////////
  cmb_output_cells u_output_cells (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .lif(lif.cells),
    .i_term_d(i_term_d),
    .i_term_clk(i_term_clk),
    .i_term_preset(i_term_preset),
    .i_term_clear(i_term_clear),
    .i_comb_sel(i_comb_sel),
    .i_comb_value(i_comb_value),
    .i_oe_term(i_oe_term),
    .i_dir_out(i_dir_out),
    .i_oe_eq_defined(i_oe_eq_defined),
    .i_pin_output(i_pin_output),
    .o_cell_out(o_output_cells),
    .o_feedback(o_cell_feedback),
    .o_pin_oe_n(o_cell_pin_oe_n)
  );

  // Upper address bits on port pins are captured here under address strobe
  cmb_input_cells u_input_cells (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_port_pins(i_port_pins),
    .i_mode(i_in_mode),
    .i_strobe_sel(i_in_strobe_sel),
    .i_term_enable(term_enable),
    .i_addr_strobe(i_port_d_pin_zero),
    .o_cell_q(o_input_cells)
  );

endmodule
`default_nettype wire

// ### cmb_pkg.sv
`default_nettype none
package cmb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned GROUP_CELLS = 8;
  localparam int unsigned OUTPUT_CELLS = 16;
  localparam int unsigned INPUT_CELLS = 24;
  localparam int unsigned CELLS_PER_TERM = 4;
  localparam int unsigned INPUT_TERMS = 6;
  localparam int unsigned BUS_BYTE = 8;
  localparam int unsigned ADDR_BITS = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Register map: page in A15..A8, offset in A7..A0
  localparam logic [7:0] BLOCK_PAGE = 8'h80;
  localparam logic [7:0] OFS_MAILBOX_OUT = 8'h04;
  localparam logic [7:0] OFS_INPUT_A = 8'h18;
  localparam logic [7:0] OFS_INPUT_B = 8'h19;
  localparam logic [7:0] OFS_INPUT_C = 8'h1a;
  localparam logic [7:0] OFS_CELLS_AB = 8'h20;
  localparam logic [7:0] OFS_CELLS_BC = 8'h21;
  localparam logic [7:0] OFS_MASK_AB = 8'h22;
  localparam logic [7:0] OFS_MASK_BC = 8'h23;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Modes and targets
  typedef enum logic [1:0] {CMB_IN_PASS, CMB_IN_LATCH, CMB_IN_REG} cmb_in_mode_t;
  typedef enum logic {CMB_BUS_WR_RD, CMB_BUS_RW_E} cmb_bus_type_t;
  typedef enum logic {CMB_LOAD_EDGE, CMB_LOAD_LEVEL} cmb_load_type_t;
  typedef enum logic [3:0] {
    CMB_TGT_NONE,
    CMB_TGT_CELLS_AB,
    CMB_TGT_CELLS_BC,
    CMB_TGT_MASK_AB,
    CMB_TGT_MASK_BC,
    CMB_TGT_MAILBOX,
    CMB_TGT_INPUT_A,
    CMB_TGT_INPUT_B,
    CMB_TGT_INPUT_C
  } cmb_target_t;

  function automatic cmb_target_t cmb_decode(input logic [15:0] addr);
    cmb_target_t tgt;
    tgt = CMB_TGT_NONE;
    if (addr[15:8] == BLOCK_PAGE)
    begin
      case (addr[7:0])
        OFS_CELLS_AB: tgt = CMB_TGT_CELLS_AB;
        OFS_CELLS_BC: tgt = CMB_TGT_CELLS_BC;
        OFS_MASK_AB: tgt = CMB_TGT_MASK_AB;
        OFS_MASK_BC: tgt = CMB_TGT_MASK_BC;
        OFS_MAILBOX_OUT: tgt = CMB_TGT_MAILBOX;
        OFS_INPUT_A: tgt = CMB_TGT_INPUT_A;
        OFS_INPUT_B: tgt = CMB_TGT_INPUT_B;
        OFS_INPUT_C: tgt = CMB_TGT_INPUT_C;
        default: tgt = CMB_TGT_NONE;
      endcase
    end
    return tgt;
  endfunction

endpackage
`default_nettype wire

// ### cmb_load_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmb_load_if;
  logic load_ab;
  logic load_bc;
  logic [cmb_pkg::GROUP_CELLS-1:0] wdata;
  logic [cmb_pkg::GROUP_CELLS-1:0] mask_ab;
  logic [cmb_pkg::GROUP_CELLS-1:0] mask_bc;
  logic [cmb_pkg::OUTPUT_CELLS-1:0] cell_q;
  modport ctrl (output load_ab, load_bc, wdata, mask_ab, mask_bc, input cell_q);
  modport cells (input load_ab, load_bc, wdata, mask_ab, mask_bc, output cell_q);
endinterface
`default_nettype wire

// ### cmb_output_cells.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_output_cells (
  input wire logic i_clock,
  input wire logic i_reset,
  cmb_load_if.cells lif,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_d,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_clk,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_preset,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_term_clear,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_comb_sel,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_comb_value,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_oe_term,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_dir_out,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_oe_eq_defined,
  input wire logic [cmb_pkg::OUTPUT_CELLS-1:0] i_pin_output,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_cell_out,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_feedback,
  output logic [cmb_pkg::OUTPUT_CELLS-1:0] o_pin_oe_n
);

  typedef struct packed {
    logic [cmb_pkg::OUTPUT_CELLS-1:0] q;
    logic [cmb_pkg::OUTPUT_CELLS-1:0] clk_prev;
  } cmb_ocell_state_t;

  cmb_ocell_state_t st_reg;
  cmb_ocell_state_t st_next;
  logic [cmb_pkg::OUTPUT_CELLS-1:0] host_load;
  logic [cmb_pkg::OUTPUT_CELLS-1:0] host_bits;
  logic [cmb_pkg::OUTPUT_CELLS-1:0] drive_on;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    host_load = {{cmb_pkg::GROUP_CELLS{lif.load_bc}} & ~lif.mask_bc,
                 {cmb_pkg::GROUP_CELLS{lif.load_ab}} & ~lif.mask_ab};
    host_bits = {lif.wdata, lif.wdata};
    st_next.clk_prev = i_term_clk;
    for (int i = 0; i < cmb_pkg::OUTPUT_CELLS; i++)
    begin
      // Host load sits above clear, preset and clock so software always wins
      if (host_load[i])
        st_next.q[i] = host_bits[i];
      else if (i_term_clear[i])
        st_next.q[i] = 1'b0;
      else if (i_term_preset[i])
        st_next.q[i] = 1'b1;
      else if (i_term_clk[i] && !st_reg.clk_prev[i])
        st_next.q[i] = i_term_d[i];
    end
    o_cell_out = (i_comb_sel & i_comb_value) | (~i_comb_sel & st_reg.q);
    o_feedback = o_cell_out;
    // Without an enable equation a declared output drives from reset on
    drive_on = i_pin_output & (~i_oe_eq_defined | i_oe_term | i_dir_out);
    o_pin_oe_n = ~drive_on;
    lif.cell_q = st_reg.q;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule
`default_nettype wire

// ### cmb_input_cells.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_input_cells (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [cmb_pkg::INPUT_CELLS-1:0] i_port_pins,
  input wire cmb_pkg::cmb_in_mode_t [cmb_pkg::INPUT_CELLS-1:0] i_mode,
  input wire logic [cmb_pkg::INPUT_TERMS-1:0] i_strobe_sel,
  input wire logic [cmb_pkg::INPUT_TERMS-1:0] i_term_enable,
  input wire logic i_addr_strobe,
  output logic [cmb_pkg::INPUT_CELLS-1:0] o_cell_q
);

  typedef struct packed {
    logic [cmb_pkg::INPUT_CELLS-1:0] held;
    logic [cmb_pkg::INPUT_TERMS-1:0] en_prev;
  } cmb_icell_state_t;

  cmb_icell_state_t st_reg;
  cmb_icell_state_t st_next;
  logic [cmb_pkg::INPUT_TERMS-1:0] enable;
  logic en_bit;
  logic rise_bit;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    en_bit = 1'b0;
    rise_bit = 1'b0;
    for (int g = 0; g < cmb_pkg::INPUT_TERMS; g++)
      enable[g] = i_strobe_sel[g] ? i_addr_strobe : i_term_enable[g];
    st_next.en_prev = enable;
    for (int i = 0; i < cmb_pkg::INPUT_CELLS; i++)
    begin
      // One enable per nibble: bits 3-0 and 7-4 of each port
      en_bit = enable[i / cmb_pkg::CELLS_PER_TERM];
      rise_bit = en_bit && !st_reg.en_prev[i / cmb_pkg::CELLS_PER_TERM];
      case (i_mode[i])
        cmb_pkg::CMB_IN_LATCH:
        begin
          if (en_bit)
            st_next.held[i] = i_port_pins[i];
          o_cell_q[i] = en_bit ? i_port_pins[i] : st_reg.held[i];
        end
        cmb_pkg::CMB_IN_REG:
        begin
          if (rise_bit)
            st_next.held[i] = i_port_pins[i];
          o_cell_q[i] = st_reg.held[i];
        end
        default:
          o_cell_q[i] = i_port_pins[i];
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule
`default_nettype wire

// ### cmb_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_top_properties (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [15:0] i_shared_addr_data_port,
  input wire logic [7:0] o_shared_addr_data_port_out,
  input wire logic o_shared_addr_data_port_oe_n,
  input wire logic i_control_pin_one,
  input wire logic i_control_pin_two,
  input wire logic i_port_d_pin_zero,
  input wire cmb_pkg::cmb_bus_type_t i_bus_type,
  input wire logic i_muxed,
  input wire logic i_program_store_used,
  input wire logic o_control_two_logic,
  input wire logic [15:0] o_latched_addr,
  input wire logic [23:0] o_input_cells,
  input wire logic [15:0] i_oe_term,
  input wire logic [15:0] i_dir_out,
  input wire logic [15:0] i_oe_eq_defined,
  input wire logic [15:0] i_pin_output,
  input wire logic [15:0] o_output_cells,
  input wire logic [15:0] o_cell_feedback,
  input wire logic [15:0] o_cell_pin_oe_n,
  input wire logic i_mailbox_en,
  input wire logic i_slave_rd_n,
  input wire logic i_slave_cs,
  input wire logic o_mailbox_oe_n
);
  logic wr_rd;
  assign wr_rd = i_muxed && i_bus_type == cmb_pkg::CMB_BUS_WR_RD;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  sequence s_addr_taken;
    i_muxed && i_port_d_pin_zero ##1 !i_port_d_pin_zero;
  endsequence
  // Two cycles of read on a steady latched address
  sequence s_read_held(ofs);
    wr_rd && !i_control_pin_one && o_latched_addr == {cmb_pkg::BLOCK_PAGE, ofs}
      ##1 wr_rd && !i_control_pin_one && $stable(o_latched_addr);
  endsequence
  oe_only_read_a: assert property (!o_shared_addr_data_port_oe_n && wr_rd |-> !i_control_pin_one
    && o_latched_addr[15:8] == cmb_pkg::BLOCK_PAGE)
    else $error("shared port driven outside a mapped read");
  read_drive_a: assert property (s_read_held(cmb_pkg::OFS_MASK_AB) |-> !o_shared_addr_data_port_oe_n)
    else $error("mapped read not driven");
  input_read_a: assert property (s_read_held(cmb_pkg::OFS_INPUT_A)
    |-> o_shared_addr_data_port_out == $past(o_input_cells[7:0]))
    else $error("input cell readback wrong");
  addr_capture_a: assert property (s_addr_taken |-> o_latched_addr == $past(i_shared_addr_data_port))
    else $error("address not captured on strobe");
  addr_hold_a: assert property (i_muxed && !i_port_d_pin_zero && !$past(i_port_d_pin_zero)
    && !$past(i_reset) |-> $stable(o_latched_addr))
    else $error("latched address moved without strobe");
  pin_enable_a: assert property (o_cell_pin_oe_n
    == ~(i_pin_output & (~i_oe_eq_defined | i_oe_term | i_dir_out)))
    else $error("pin driver enable wrong");
  node_feedback_a: assert property (o_cell_feedback == o_output_cells)
    else $error("feedback differs from cell output");
  spare_ctrl_a: assert property (o_control_two_logic
    == (!i_program_store_used && i_control_pin_two))
    else $error("spare control input wrong");
  mbox_read_a: assert property (o_mailbox_oe_n
    == !(i_mailbox_en && i_slave_cs && !i_slave_rd_n))
    else $error("mailbox read enable wrong");
endmodule
bind cmb_top cmb_top_properties i_cmb_top_properties (.*);
`default_nettype wire

// ### cmb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_oe_n,
  output logic [15:0] o_shared_addr_data_port,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_fetch_n,
  output logic o_addr_strobe
);
  logic [8:0] rd_word;
  event rd_done;
  initial
  begin
    o_shared_addr_data_port = 16'h0000;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_fetch_n = 1'b1;
    o_addr_strobe = 1'b0;
    rd_word = 9'h000;
  end
  task automatic addr_phase(input logic [15:0] addr);
  begin
    @(negedge i_clock);
    o_shared_addr_data_port = addr;
    o_addr_strobe = 1'b1;
    @(negedge i_clock);
    o_addr_strobe = 1'b0;
  end
  endtask
  // Strobe low two cycles, then one idle cycle before the next access
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
  begin
    addr_phase(addr);
    o_shared_addr_data_port = {addr[15:8], data};
    o_wr_n = 1'b0;
    repeat (2) @(negedge i_clock);
    o_wr_n = 1'b1;
    @(negedge i_clock);
    o_shared_addr_data_port = ~o_shared_addr_data_port;
  end
  endtask
  // Released bus reads as all ones through the pull-ups
  task automatic rd(input logic [15:0] addr);
  begin
    addr_phase(addr);
    o_shared_addr_data_port = ~addr;
    o_rd_n = 1'b0;
    repeat (2) @(negedge i_clock);
    rd_word = {i_rdata_oe_n, i_rdata_oe_n ? 8'hff : i_rdata};
    o_rd_n = 1'b1;
    -> rd_done;
  end
  endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clock = 1'b0, i_reset = 1'b1;
  logic [15:0] i_shared_addr_data_port, o_latched_addr, o_output_cells, o_cell_feedback, o_cell_pin_oe_n;
  logic [15:0] i_term_d = 16'h0000, i_term_clk = 16'h0000, i_term_preset = 16'h0000;
  logic [15:0] i_term_clear = 16'h0000, i_comb_sel = 16'h0000, i_comb_value = 16'h0000;
  logic [15:0] i_oe_term = 16'h0000, i_dir_out = 16'h0000, i_oe_eq_defined = 16'h0000;
  logic [15:0] i_pin_output = 16'h0000;
  logic [7:0] o_shared_addr_data_port_out, o_mailbox_data, m, d;
  logic o_shared_addr_data_port_oe_n, i_control_pin_zero, i_control_pin_one, i_control_pin_two;
  logic i_port_d_pin_zero, o_control_two_logic, o_mailbox_oe_n;
  logic i_muxed = 1'b1, i_program_store_used = 1'b0, i_mailbox_en = 1'b0;
  logic i_slave_rd_n = 1'b1, i_slave_wr_n = 1'b1, i_slave_cs = 1'b0;
  cmb_pkg::cmb_bus_type_t i_bus_type = cmb_pkg::CMB_BUS_WR_RD;
  cmb_pkg::cmb_load_type_t i_load_type = cmb_pkg::CMB_LOAD_EDGE;
  cmb_pkg::cmb_in_mode_t [23:0] i_in_mode;
  logic [23:0] i_port_pins = 24'h00_0000, o_input_cells, p;
  logic [5:0] i_in_strobe_sel = 6'h00, i_in_term_enable = 6'h00;
  logic [7:0] cells [2], masks [2];
  logic [8:0] expq [$];
  logic [31:0] r;
  integer seed;
  int mismatches = 0, samples_checked = 0;

  always #25 i_clock = ~i_clock;
  cmb_top i_cmb_top (.*);
  cmb_host_model i_host (.i_clock(i_clock), .i_rdata(o_shared_addr_data_port_out), .i_rdata_oe_n(o_shared_addr_data_port_oe_n),
    .o_shared_addr_data_port(i_shared_addr_data_port), .o_wr_n(i_control_pin_zero), .o_rd_n(i_control_pin_one),
    .o_fetch_n(i_control_pin_two), .o_addr_strobe(i_port_d_pin_zero));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ad(input logic [7:0] ofs);
    return {cmb_pkg::BLOCK_PAGE, ofs};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [8:0] e);
  begin
    expq.push_back(e);
    i_host.rd(a);
  end
  endtask
  task automatic close_out;
  begin
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  forever
  begin
    @(i_host.rd_done);
    cmp(i_host.rd_word, expq.pop_front());
  end
  initial
  begin
    #100000;
    mismatches++;
    close_out;
  end
  initial
  begin
    seed = 32'h0000_2306;
    cells = '{8'h00, 8'h00};
    masks = '{8'h00, 8'h00};
    for (int k = 0; k < 24; k++)
      i_in_mode[k] = cmb_pkg::CMB_IN_PASS;
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    rd_chk(ad(cmb_pkg::OFS_MASK_AB), 9'h000);
    rd_chk(ad(cmb_pkg::OFS_MASK_BC), 9'h000);
    rd_chk(ad(8'h30), 9'h1ff);
    rd_chk(16'h4022, 9'h1ff);
    for (int i = 0; i < 8; i++)
    begin
      int g;
      g = i % 2;
      r = $random(seed);
      {m, d} = r[15:0];
      {i_oe_term, i_dir_out} = {r[31:16], r[23:8]};
      i_oe_eq_defined = r[27:12];
      i_pin_output = r[31:16] ^ r[15:0];
      i_program_store_used = r[5];
      i_load_type = cmb_pkg::cmb_load_type_t'(i[1]);
      i_host.wr(ad(cmb_pkg::OFS_MASK_AB + g), m);
      i_host.wr(ad(cmb_pkg::OFS_CELLS_AB + g), d);
      masks[g] = m;
      cells[g] = (cells[g] & m) | (d & ~m);
      rd_chk(ad(cmb_pkg::OFS_MASK_AB + g), {1'b0, m});
      rd_chk(ad(cmb_pkg::OFS_MASK_AB + !g), {1'b0, masks[!g]});
      rd_chk(ad(cmb_pkg::OFS_CELLS_AB + g), {1'b0, cells[g]});
      cmp(o_output_cells, {cells[1], cells[0]});
    end
    p = $random(seed);
    i_port_pins = p;
    for (int k = 0; k < 3; k++)
      rd_chk(ad(cmb_pkg::OFS_INPUT_A + k), {1'b0, p[8*k +: 8]});
    for (int k = 8; k < 24; k++)
      i_in_mode[k] = cmb_pkg::CMB_IN_LATCH;
    i_in_term_enable = 6'b00_1100;
    @(negedge i_clock);
    i_in_term_enable = 6'b00_1000;
    i_port_pins = ~p;
    rd_chk(ad(cmb_pkg::OFS_INPUT_B), {1'b0, ~p[15:12], p[11:8]});
    i_in_strobe_sel = 6'b11_0000;
    i_port_pins[23:16] = p[23:16];
    i_host.wr(ad(8'h30), 8'hff);
    i_port_pins[23:16] = ~p[23:16];
    @(negedge i_clock);
    cmp(o_input_cells[23:16], p[23:16]);
    d = $random(seed);
    i_host.wr(ad(cmb_pkg::OFS_MAILBOX_OUT), d);
    cmp(o_latched_addr, ad(cmb_pkg::OFS_MAILBOX_OUT));
    {i_mailbox_en, i_slave_cs, i_slave_rd_n} = 3'b110;
    @(negedge i_clock);
    cmp({o_mailbox_oe_n, o_mailbox_data}, {1'b0, d});
    i_slave_rd_n = 1'b1;
    for (int k = 0; k < 8; k++)
      i_in_mode[k] = cmb_pkg::CMB_IN_LATCH;
    i_port_pins[7:0] = ~d;
    i_slave_wr_n = 1'b0;
    @(negedge i_clock);
    i_slave_wr_n = 1'b1;
    @(negedge i_clock);
    i_port_pins[7:0] = d;
    rd_chk(ad(cmb_pkg::OFS_INPUT_A), {1'b0, ~d});
    i_term_clear = 16'h00ff;
    i_load_type = cmb_pkg::CMB_LOAD_LEVEL;
    fork
      i_host.wr(ad(cmb_pkg::OFS_CELLS_AB), d);
      begin
        repeat (3) @(negedge i_clock);
        cmp(o_output_cells[7:0], d & ~masks[0]);
      end
    join
    i_term_clear = 16'h0000;
    cells[0] = 8'h00;
    r = $random(seed);
    {i_comb_sel, i_comb_value} = r;
    @(negedge i_clock);
    cmp(o_cell_feedback, (r[31:16] & r[15:0]) | (~r[31:16] & {cells[1], cells[0]}));
    close_out;
  end
endmodule
`default_nettype wire
